// ==== logic/dswp_pkg.sv ====
// package of constants for the display serial write port
package dswp_pkg;

  // word geometry
  localparam int DSWP_BYTE_BITS = 8;
  localparam int DSWP_CNT_W = 4;
  localparam logic [3:0] DSWP_BITS_4W = 4'h8;
  localparam logic [3:0] DSWP_BITS_3W = 4'h9;

  // values after reset
  localparam logic [3:0] DSWP_CNT_RST = 4'h0;
  localparam logic [8:0] DSWP_SHIFT_RST = 9'h000;

  // bus-select pin levels
  localparam logic DSWP_MODE_4W = 1'b0;
  localparam logic DSWP_MODE_3W = 1'b1;

  // fifo depth
  localparam int DSWP_FIFO_DEPTH = 16;

endpackage

// ==== logic/dswp_port.sv ====
// serial write port of the display controller with its receive fifo
// Operation
// - interface mode fixed by bus-select pin; only 4-wire and 3-wire serial exist
// - bus-select low gives 4-wire, high gives 3-wire 9-bit mode
// - clock pin is shift clock, data pin is serial data input
// - 4-wire: shift 8 bits on rising clock edges, msb first
// - 4-wire: command/data pin sampled on eighth clock, byte routed then
// - write only; no read-back path of any kind
// - 3-wire: nine bits per word, flag first, completes on ninth clock
// - 3-wire: flag one goes to display ram, zero to command register
// - transfers taken only while chip select is low
// - active-low reset pin returns shift logic, overrun and busy to initial state; fifo keeps its words
`timescale 1ns/100ps

// ----------------------------------------
// fifo of received words
// ----------------------------------------
module dswp_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  // full and empty straight from the occupancy count; depth is compared at the
  // count's own width, since a power-of-two depth does not fit the pointer width
  assign in_ready = (count_r != (AW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign out_data = mem[rd_ptr_r];

  // storage has no reset, only pointers and count do
  always_ff @(posedge sys_clk)
  begin
    if (push)
    begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  // pointer and count update
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_r <= AW'(wr_ptr_r + 1'b1);
      if (pop)
        rd_ptr_r <= AW'(rd_ptr_r + 1'b1);
      count_r <= (AW+1)'(count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
    end
  end
endmodule // dswp_fifo

// ----------------------------------------
// serial port top
// ----------------------------------------
module dswp_port (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // host pins
  input wire logic reset_n_input,
  input wire logic bus_mode_select_pin,
  input wire logic select_n_pin,
  input wire logic shift_clk_pin,
  input wire logic shift_data_in,
  input wire logic cmd_data_pin,
  output logic busy_n_output,
  // internal controller side: busy from the core, words out
  input wire logic core_busy,
  output logic word_valid,
  output logic word_is_data,
  output logic [7:0] word_byte,
  input wire logic word_ready,
  // overflow marker
  output logic overrun_r
);
  // three-stage synchronisers for every pin
  logic [2:0] sel_n_s;
  logic [2:0] sclk_s;
  logic [2:0] sdi_s;
  logic [2:0] dc_s;
  logic [2:0] msel_s;
  logic [2:0] prst_s;
  logic sel_n_r;
  logic sclk_r;
  logic sdi_r;
  logic dc_r;
  logic mode_r;
  logic prst_n_r;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic [8:0] shift_r;
  logic [8:0] shift_nxt;
  logic push_r;
  logic [8:0] push_word_r;
  logic busy_n_r;
  logic fifo_ready;
  logic fifo_valid;
  logic [8:0] fifo_data;

  // filtered levels: a change counts once stages two and three agree
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      sel_n_s <= 3'h7;
      sclk_s <= 3'h0;
      sdi_s <= 3'h0;
      dc_s <= 3'h0;
      msel_s <= 3'h0;
      prst_s <= 3'h0;
      sel_n_r <= 1'b1;
      sclk_r <= 1'b0;
      sdi_r <= 1'b0;
      dc_r <= 1'b0;
      mode_r <= dswp_pkg::DSWP_MODE_4W;
      prst_n_r <= 1'b0;
    end
    else
    begin
      sel_n_s <= {sel_n_s[1:0], select_n_pin};
      sclk_s <= {sclk_s[1:0], shift_clk_pin};
      sdi_s <= {sdi_s[1:0], shift_data_in};
      dc_s <= {dc_s[1:0], cmd_data_pin};
      msel_s <= {msel_s[1:0], bus_mode_select_pin};
      prst_s <= {prst_s[1:0], reset_n_input};
      if (sel_n_s[1] == sel_n_s[2]) sel_n_r <= sel_n_s[2];
      if (sclk_s[1] == sclk_s[2]) sclk_r <= sclk_s[2];
      if (sdi_s[1] == sdi_s[2]) sdi_r <= sdi_s[2];
      if (dc_s[1] == dc_s[2]) dc_r <= dc_s[2];
      if (msel_s[1] == msel_s[2]) mode_r <= msel_s[2];
      if (prst_s[1] == prst_s[2]) prst_n_r <= prst_s[2];
    end
  end

  // decode: rising shift clock inside an active frame
  wire sclk_rise = sclk_s[2] && (sclk_s[1] == sclk_s[2]) && !sclk_r;
  wire active = !sel_n_r && prst_n_r;
  wire take_bit = active && sclk_rise;
  wire [3:0] word_bits = (mode_r == dswp_pkg::DSWP_MODE_3W) ? dswp_pkg::DSWP_BITS_3W
                                                           : dswp_pkg::DSWP_BITS_4W;
  wire last_bit = take_bit && (cnt_r == word_bits - 4'h1);
  wire [8:0] shifted = {shift_r[7:0], sdi_r};
  // 4-wire takes the pin on the eighth clock; 3-wire ignores the pin
  wire flag_4w = dc_r;
  wire flag_3w = shift_r[7];
  wire word_flag = (mode_r == dswp_pkg::DSWP_MODE_3W) ? flag_3w : flag_4w;

  // counter and shifter next values; deselect drops a partial word
  assign cnt_nxt = !active ? dswp_pkg::DSWP_CNT_RST
                 : last_bit ? dswp_pkg::DSWP_CNT_RST
                 : take_bit ? 4'(cnt_r + 4'h1) : cnt_r;
  assign shift_nxt = !active ? dswp_pkg::DSWP_SHIFT_RST : take_bit ? shifted : shift_r;

  // shift state; reset pin held low clears it too
  always_ff @(posedge sys_clk)
  begin
    if (rst || !prst_n_r)
    begin
      cnt_r <= dswp_pkg::DSWP_CNT_RST;
      shift_r <= dswp_pkg::DSWP_SHIFT_RST;
      push_r <= 1'b0;
      push_word_r <= 9'h000;
      overrun_r <= 1'b0;
      busy_n_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      shift_r <= shift_nxt;
      push_r <= last_bit;
      push_word_r <= {word_flag, shifted[7:0]};
      // a word arriving at a full fifo is lost; marker is sticky until reset
      if (push_r && !fifo_ready)
        overrun_r <= 1'b1;
      // busy low while the core works or the fifo has no room
      busy_n_r <= !core_busy && fifo_ready;
    end
  end

  dswp_fifo #(
    .WIDTH(9),
    .DEPTH(dswp_pkg::DSWP_FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .in_valid(push_r),
    .in_data(push_word_r),
    .in_ready(fifo_ready),
    .out_valid(fifo_valid),
    .out_data(fifo_data),
    .out_ready(word_ready)
  );

  // outputs; no read path exists toward the host
  assign busy_n_output = busy_n_r;
  assign word_valid = fifo_valid;
  assign word_is_data = fifo_data[8];
  assign word_byte = fifo_data[7:0];

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  sequence frame_idle_s;
    !active;
  endsequence

  deselect_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
    frame_idle_s |=> cnt_r == 4'h0) else $error("counter not cleared on deselect");
  word_push_a: assert property (@(posedge sys_clk) disable iff (rst)
    last_bit |=> push_r) else $error("word not pushed on last bit");
  no_push_idle_a: assert property (@(posedge sys_clk) disable iff (rst)
    !last_bit |=> !push_r) else $error("push without last bit");
  count_bound_a: assert property (@(posedge sys_clk) disable iff (rst)
    cnt_r < 4'h9) else $error("bit counter beyond nine");
  four_wire_len_a: assert property (@(posedge sys_clk) disable iff (rst)
    (mode_r == 1'b0) |-> cnt_r < 4'h8) else $error("4-wire word longer than eight");
  flag_route_a: assert property (@(posedge sys_clk) disable iff (rst)
    (last_bit && mode_r) |=> push_word_r[8] == $past(shift_r[7])) else $error("3-wire flag misrouted");
  pin_reset_a: assert property (@(posedge sys_clk) disable iff (rst)
    !prst_n_r |=> cnt_r == 4'h0 && !push_r) else $error("reset pin did not clear port");
  byte_order_a: assert property (@(posedge sys_clk) disable iff (rst)
    take_bit && active |=> shift_r[0] == $past(sdi_r)) else $error("serial bit not shifted in lsb");
endmodule // dswp_port

// ==== test/dswp_host_model.sv ====
// host serial master model driving the port pins
`timescale 1ns/100ps
module dswp_host_model (
  // clock
  input wire logic sys_clk,
  // host pins
  output logic select_n_pin,
  output logic shift_clk_pin,
  output logic shift_data_in,
  output logic cmd_data_pin
);
  // idle host: deselected, clock parked low
  initial
  begin
    select_n_pin = 1'b1;
    shift_clk_pin = 1'b0;
    shift_data_in = 1'b0;
    cmd_data_pin = 1'b0;
  end

  // sends the n low bits of w msb first; each level held 4 cycles so the
  // synchronisers see it, and the clock stands still between frames
  task automatic send_bits(input logic [8:0] w, input int n, input logic cd, input logic sel);
    select_n_pin <= ~sel;
    cmd_data_pin <= cd;
    repeat (4) @(posedge sys_clk);
    for (int i = n - 1; i >= 0; i--)
    begin
      shift_data_in <= w[i];
      repeat (4) @(posedge sys_clk);
      shift_clk_pin <= 1'b1;
      repeat (4) @(posedge sys_clk);
      shift_clk_pin <= 1'b0;
    end
    repeat (4) @(posedge sys_clk);
    select_n_pin <= 1'b1;
    shift_data_in <= ~shift_data_in; // released line shows no stale bit
    @(posedge sys_clk);
  endtask
endmodule // dswp_host_model

// ==== test/tb_top.sv ====
// self-checking bench for the display serial write port
`timescale 1ns/100ps
module tb_top;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic reset_n_input = 1'b1;
  logic bus_mode_select_pin = 1'b0;
  logic core_busy = 1'b0;
  logic word_ready = 1'b0;
  logic drain = 1'b1;
  logic select_n_pin, shift_clk_pin, shift_data_in, cmd_data_pin;
  logic busy_n_output, word_valid, word_is_data, overrun_r;
  logic [7:0] word_byte;
  logic [31:0] seed = 32'hE1A09709;
  logic [8:0] exp_q[$];
  int n_fail = 0;
  int checked = 0;

  always #25 sys_clk = ~sys_clk;

  dswp_host_model u_host (.sys_clk(sys_clk), .select_n_pin(select_n_pin), .shift_clk_pin(shift_clk_pin),
    .shift_data_in(shift_data_in), .cmd_data_pin(cmd_data_pin));

  dswp_port u_dut (.sys_clk(sys_clk), .rst(rst), .reset_n_input(reset_n_input),
    .bus_mode_select_pin(bus_mode_select_pin), .select_n_pin(select_n_pin), .shift_clk_pin(shift_clk_pin),
    .shift_data_in(shift_data_in), .cmd_data_pin(cmd_data_pin), .busy_n_output(busy_n_output),
    .core_busy(core_busy), .word_valid(word_valid), .word_is_data(word_is_data), .word_byte(word_byte),
    .word_ready(word_ready), .overrun_r(overrun_r));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic check(input logic [8:0] got, input logic [8:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // one whole word; expectation queued first since the pop can beat the host's return
  task automatic word(input logic m, input logic f, input logic [7:0] b);
    bus_mode_select_pin <= m;
    repeat (4) @(posedge sys_clk);
    if (exp_q.size() < dswp_pkg::DSWP_FIFO_DEPTH)
      exp_q.push_back({f, b});
    u_host.send_bits(m ? {f, b} : {1'b0, b}, m ? 9 : 8, m ? 1'b0 : f, 1'b1);
  endtask

  // consumer stalls at random; every popped word is compared with the model
  always @(posedge sys_clk)
  begin
    if (word_valid === 1'b1 && word_ready === 1'b1)
      check({word_is_data, word_byte}, exp_q.size() > 0 ? exp_q.pop_front() : ~{word_is_data, word_byte});
    seed <= xs(seed);
    word_ready <= drain & seed[0];
  end

  initial
  begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (8) @(posedge sys_clk);
    for (int i = 0; i < 12; i++)
      word(i[0], i[1], seed[15:8]);
    $display("test words done");
    u_host.send_bits(9'h0A5, 5, 1'b1, 1'b1);
    word(1'b0, 1'b1, 8'h3C);
    u_host.send_bits(9'h1FF, 9, 1'b1, 1'b0);
    word(1'b1, 1'b0, 8'hC3);
    fork
      u_host.send_bits(9'h155, 9, 1'b0, 1'b1);
      begin
        repeat (30) @(posedge sys_clk);
        reset_n_input <= 1'b0;
        repeat (8) @(posedge sys_clk);
        reset_n_input <= 1'b1;
      end
    join
    word(1'b1, 1'b1, 8'h81);
    $display("test framing done");
    drain <= 1'b0;
    for (int i = 0; i < 17; i++)
      word(1'b0, i[0], seed[23:16]);
    check({8'h00, busy_n_output}, 9'h000);
    check({8'h00, overrun_r}, 9'h001);
    drain <= 1'b1;
    repeat (150) @(posedge sys_clk);
    check({8'h00, busy_n_output}, 9'h001);
    core_busy <= 1'b1;
    repeat (4) @(posedge sys_clk);
    check({8'h00, busy_n_output}, 9'h000);
    core_busy <= 1'b0;
    reset_n_input <= 1'b0;
    repeat (8) @(posedge sys_clk);
    reset_n_input <= 1'b1;
    repeat (8) @(posedge sys_clk);
    check({8'h00, overrun_r}, 9'h000);
    check(9'(exp_q.size()), 9'h000);
    $display("test fifo done");
    report_and_stop();
  end

  // watchdog: nearly seven times the expected run
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    report_and_stop();
  end
endmodule // tb_top
